// ### verilog/pec_link_pkg.sv
`default_nettype none
package pec_link_pkg;

  // ==========================================================
  // timing
  localparam int CLK_PERIOD_NS   = 10;
  localparam int SCK_HALF_NS     = 500;
  localparam int SELECT_GAP_NS     = 1000;
  localparam int SCK_HALF_CYCLES   = (SCK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SELECT_GAP_CYCLES = (SELECT_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [7:0] SCK_HALF_LAST   = 8'(SCK_HALF_CYCLES - 1);
  localparam logic [7:0] SELECT_GAP_LAST = 8'(SELECT_GAP_CYCLES - 1);

  // ==========================================================
  // framing
  localparam logic [14:0] PEC_SEED     = 15'h0010;
  localparam logic [1:0]  CMD_PEC_HI   = 2'h2;
  localparam logic [1:0]  CMD_PEC_LO   = 2'h3;
  localparam logic [2:0]  GROUP_PEC_HI = 3'h6;
  localparam logic [2:0]  GROUP_PEC_LO = 3'h7;
  localparam logic [7:0]  IDLE_BYTE    = 8'hFF;

  typedef enum logic [1:0] {
    OP_CMD   = 2'b00,
    OP_WRITE = 2'b01,
    OP_READ  = 2'b10,
    OP_POLL  = 2'b11
  } op_type;

  typedef struct packed {
    op_type      op;
    logic [15:0] cmd;
    logic [3:0]  devCount;
  } request_type;

  typedef struct packed {
    logic [3:0] dev;
    logic [2:0] index;
    logic [7:0] data;
  } read_byte_type;

  // one bit into the check accumulator
  function automatic logic [14:0] pec_step(input logic [14:0] c, input logic din);
    logic        fb;
    logic [14:0] n;
    fb    = din ^ c[14];     // [RL3]
    n     = {c[13:0], fb};   // [RL4]
    n[3]  = fb ^ c[2];       // [RL1]
    n[4]  = fb ^ c[3];
    n[7]  = fb ^ c[6];
    n[8]  = fb ^ c[7];
    n[10] = fb ^ c[9];
    n[14] = fb ^ c[13];
    return n;
  endfunction

endpackage
`default_nettype wire

// ### verilog/pec_link_host.sv
// Summary of operation
// RL1: check code is 15-bit CRC, polynomial x15+x14+x10+x8+x7+x4+x3+1.
// RL2: accumulator starts each checked unit at seed with only bit 4 set.
// RL3: feedback is input bit XOR bit 14; taps XOR feedback with lower bits.
// RL4: accumulator shifts upward; tap positions load tap inputs, others neighbour.
// RL5: sent check word is the 15-bit value with zero appended as LSB.
// RL6: code covers every bit in order, final after the last data bit.
// RL7: first check byte is bits 14..7, second is bits 6..0 then zero.
// RL8: device checks command and data, acts only on match.
// RL9: device appends its computed check bytes to read data.
// RL10: host sends command high, command low, check high, check low.
// RL11: chained write sends top device group first, each with its check bytes.
// RL12: device shifts out own group then relays data from above.
// RL13: all devices decode together; chain acts as cascaded shift register.
// RL14: with select held after conversion, output low while busy.
// RL15: output returns high as soon as select rises.
// RL16: after status poll command, output low while busy, high when done.
// RL17: pulse link replies to each master pulse with busy or done.
// RL18: long select-high pulse abandons polling on pulse link.
// RL19: bottom device outputs zero for first N clocks, then stack status.
// RL20: pulse link chain replies meaningful only after N pulses.
// RL21: host may wait out conversion time instead of polling.
// RL22: every byte is sent most significant bit first.
// RL23: select stays low through whole sequence; writes land on its rise.
// RL24: command check word covers both command bytes as one unit.
// RL25: device reseeds accumulator at command and at each data group.
// RL26: device ignores command or group whose check word mismatches.
`timescale 1ns/100ps
`default_nettype none
module pec_link_host (
  input  wire logic                        clk,
  input  wire logic                        rst_n,
  input  wire logic                        reqValid,
  output logic                             reqReady,
  input  wire pec_link_pkg::request_type   req,
  input  wire logic                        wrValid,
  output logic                             wrReady,
  input  wire logic [7:0]                  wrByte,
  output logic                             rdValid,
  output pec_link_pkg::read_byte_type      rdData,
  output logic                             groupDone,
  output logic                             checkOk,
  input  wire logic                        pollAbort,
  output logic                             convDone,
  output logic                             done,
  output logic                             chipSelect_n,
  output logic                             sck,
  output logic                             sdi,
  input  wire logic                        sdo
);

  // ==========================================================
  // state
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_LOAD  = 3'b001,
    ST_SHIFT = 3'b010,
    ST_POLL  = 3'b011,
    ST_GAP   = 3'b100
  } state_type;

  state_type                 state_q;
  pec_link_pkg::request_type req_q;
  logic                      inData_q, phase_q;
  logic [1:0]                pos_q;
  logic [2:0]                gb_q, bit_q;
  logic [3:0]                dev_q;
  logic [7:0]                cnt_q, tx_q, rx_q, pecHi_q;
  logic [14:0]               crc_q;
  logic [4:0]                pollCnt_q;
  logic                      sdoMeta_q, sdoSync_q;
  logic                      halfEnd, bitEnd, byteEnd, isRx, covering;
  logic                      crcBit, loadGo, lastDev, statusHigh;
  logic [7:0]                loadByte, rxByte;

  // ==========================================================
  // pin synchroniser
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sdoMeta_q <= 1'b1;
      sdoSync_q <= 1'b1;
    end else begin
      sdoMeta_q <= sdo;
      sdoSync_q <= sdoMeta_q;
    end
  end

  // ==========================================================
  // decode
  assign halfEnd  = cnt_q == pec_link_pkg::SCK_HALF_LAST;
  assign bitEnd   = (state_q == ST_SHIFT || state_q == ST_POLL) && phase_q && halfEnd;
  assign byteEnd  = state_q == ST_SHIFT && bitEnd && bit_q == 3'h7;
  assign isRx     = inData_q && req_q.op == pec_link_pkg::OP_READ;
  assign covering = inData_q ? (gb_q < pec_link_pkg::GROUP_PEC_HI) : (pos_q < 2'h2); // [RL24]
  assign crcBit   = isRx ? sdoSync_q : tx_q[7];
  assign rxByte   = {rx_q[6:0], sdoSync_q};
  assign lastDev  = ({1'b0, dev_q} + 5'h01) >= {1'b0, req_q.devCount};
  // the first N samples are the chain's fill, not status
  assign statusHigh = state_q == ST_POLL && bitEnd && sdoSync_q
                      && pollCnt_q >= {1'b0, req_q.devCount}; // [RL19]
  assign wrReady  = state_q == ST_LOAD && inData_q && req_q.op == pec_link_pkg::OP_WRITE
                    && gb_q < pec_link_pkg::GROUP_PEC_HI;
  assign loadGo   = state_q == ST_LOAD && (!wrReady || wrValid);
  assign reqReady = state_q == ST_IDLE;
  assign sdi      = tx_q[7]; // [RL22]

  always_comb begin
    loadByte = pec_link_pkg::IDLE_BYTE;
    if (!inData_q) begin
      case (pos_q) // [RL10]
        2'h0:    loadByte = req_q.cmd[15:8];
        2'h1:    loadByte = req_q.cmd[7:0];
        2'h2:    loadByte = crc_q[14:7];       // [RL7]
        default: loadByte = {crc_q[6:0], 1'b0}; // [RL5]
      endcase
    end else if (req_q.op == pec_link_pkg::OP_WRITE) begin
      if (gb_q == pec_link_pkg::GROUP_PEC_HI) begin
        loadByte = crc_q[14:7]; // [RL11]
      end else if (gb_q == pec_link_pkg::GROUP_PEC_LO) begin
        loadByte = {crc_q[6:0], 1'b0};
      end else begin
        loadByte = wrByte;
      end
    end
  end

  // ==========================================================
  // sequencer and bit engine
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_q      <= ST_IDLE;
      req_q        <= '0;
      inData_q     <= 1'b0;
      pos_q        <= 2'h0;
      gb_q         <= 3'h0;
      dev_q        <= 4'h0;
      phase_q      <= 1'b0;
      cnt_q        <= 8'h00;
      bit_q        <= 3'h0;
      tx_q         <= pec_link_pkg::IDLE_BYTE;
      rx_q         <= 8'h00;
      pollCnt_q    <= 5'h00;
      chipSelect_n <= 1'b1;
      sck          <= 1'b0;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (reqValid) begin
            req_q        <= req;
            inData_q     <= 1'b0;
            pos_q        <= 2'h0;
            chipSelect_n <= 1'b0; // [RL23]
            state_q      <= ST_LOAD;
          end
        end
        ST_LOAD: begin
          if (loadGo) begin
            tx_q    <= loadByte;
            bit_q   <= 3'h0;
            phase_q <= 1'b0;
            cnt_q   <= 8'h00;
            state_q <= ST_SHIFT;
          end
        end
        ST_SHIFT, ST_POLL: begin
          cnt_q <= halfEnd ? 8'h00 : cnt_q + 8'h01;
          if (halfEnd) begin
            phase_q <= !phase_q;
            sck     <= !phase_q;
          end
          if (bitEnd) begin
            tx_q  <= {tx_q[6:0], 1'b1}; // [RL22]
            rx_q  <= rxByte;
            bit_q <= bit_q + 3'h1;
          end
          if (byteEnd) begin
            state_q <= ST_LOAD;
            if (!inData_q) begin
              pos_q <= pos_q + 2'h1;
              if (pos_q == pec_link_pkg::CMD_PEC_LO) begin
                inData_q  <= req_q.op == pec_link_pkg::OP_WRITE
                             || req_q.op == pec_link_pkg::OP_READ;
                gb_q      <= 3'h0;
                dev_q     <= 4'h0;
                pollCnt_q <= 5'h00;
                tx_q      <= pec_link_pkg::IDLE_BYTE;
                if (req_q.op == pec_link_pkg::OP_POLL) begin
                  state_q <= ST_POLL; // [RL16]
                end else if (req_q.op == pec_link_pkg::OP_CMD) begin
                  state_q <= ST_GAP; // [RL21]
                end
              end
            end else begin
              gb_q <= gb_q + 3'h1;
              if (gb_q == pec_link_pkg::GROUP_PEC_LO) begin
                dev_q <= dev_q + 4'h1;
                if (lastDev) begin
                  state_q <= ST_GAP; // [RL23]
                end
              end
            end
          end
          if (state_q == ST_POLL) begin
            if (bitEnd) begin
              pollCnt_q <= (pollCnt_q == 5'h1F) ? pollCnt_q : pollCnt_q + 5'h01;
            end
            // an abort may land mid-bit, so the clock is parked low here
            if (pollAbort || statusHigh) begin // [RL19]
              state_q <= ST_GAP;
              cnt_q   <= 8'h00;
              sck     <= 1'b0;
              phase_q <= 1'b0;
            end
          end
        end
        ST_GAP: begin
          chipSelect_n <= 1'b1;
          cnt_q        <= cnt_q + 8'h01;
          if (cnt_q == pec_link_pkg::SELECT_GAP_LAST) begin
            state_q <= ST_IDLE;
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // ==========================================================
  // check accumulator
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      crc_q <= pec_link_pkg::PEC_SEED;
    end else if (state_q == ST_IDLE || (state_q == ST_LOAD && inData_q && gb_q == 3'h0)) begin
      crc_q <= pec_link_pkg::PEC_SEED; // [RL2]
    end else if (state_q == ST_SHIFT && bitEnd && covering) begin
      crc_q <= pec_link_pkg::pec_step(crc_q, crcBit); // [RL6]
    end
  end

  // ==========================================================
  // answers
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rdValid   <= 1'b0;
      rdData    <= '0;
      groupDone <= 1'b0;
      checkOk   <= 1'b0;
      pecHi_q   <= 8'h00;
      convDone  <= 1'b0;
      done      <= 1'b0;
    end else begin
      rdValid   <= byteEnd && isRx && gb_q < pec_link_pkg::GROUP_PEC_HI;
      groupDone <= byteEnd && isRx && gb_q == pec_link_pkg::GROUP_PEC_LO;
      convDone  <= statusHigh && !pollAbort;
      done      <= state_q == ST_GAP && cnt_q == pec_link_pkg::SELECT_GAP_LAST;
      if (byteEnd && isRx) begin
        rdData <= '{dev: dev_q, index: gb_q, data: rxByte}; // [RL12]
        if (gb_q == pec_link_pkg::GROUP_PEC_HI) begin
          pecHi_q <= rxByte;
        end
        if (gb_q == pec_link_pkg::GROUP_PEC_LO) begin
          checkOk <= {pecHi_q, rxByte} == {crc_q, 1'b0}; // [RL9]
        end
      end
    end
  end

  // ==========================================================
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence s_sck_high;
    sck [*8];
  endsequence

  a_seed_group: assert property (state_q == ST_LOAD && inData_q && gb_q == 3'h0
    |=> crc_q == pec_link_pkg::PEC_SEED) else $error("group not reseeded"); // [RL2]
  a_cmd_pec_hi: assert property (loadGo && !inData_q && pos_q == 2'h2
    |=> tx_q == $past(crc_q[14:7])) else $error("bad command check byte"); // [RL7]
  a_pec_lsb: assert property (loadGo && !inData_q && pos_q == 2'h3
    |=> tx_q[0] == 1'b0) else $error("check word lsb not zero"); // [RL5]
  a_select_low: assert property (state_q == ST_SHIFT |-> !chipSelect_n)
    else $error("select high mid byte"); // [RL23]
  a_msb_first: assert property (loadGo |=> sdi == $past(loadByte[7]))
    else $error("msb not first"); // [RL22]
  a_crc_hold: assert property (state_q == ST_SHIFT && !(bitEnd && covering)
    |=> $stable(crc_q)) else $error("check code moved"); // [RL6]
  a_poll_fill: assert property (state_q == ST_POLL && bitEnd && !pollAbort
    && pollCnt_q < {1'b0, req_q.devCount} |=> state_q == ST_POLL)
    else $error("poll ended in fill"); // [RL19]
  a_wr_pec: assert property (loadGo && inData_q && req_q.op == pec_link_pkg::OP_WRITE
    && gb_q == 3'h6 |=> tx_q == $past(crc_q[14:7])) else $error("bad data check"); // [RL11]
  a_sck_width: assert property ($rose(sck) |-> s_sck_high)
    else $error("short clock high"); // [RL22]

endmodule // pec_link_host
`default_nettype wire

// ### sim/dev_chain.sv
`timescale 1ns/100ps
`default_nettype none
module dev_chain #(
  parameter int          N_DEV       = 2,
  parameter int          BUSY_CYCLES = 15000,
  parameter logic [15:0] WR_CMD      = 16'h0001,
  parameter logic [15:0] RD_CMD      = 16'h0002,
  parameter logic [15:0] CONV_CMD    = 16'h0260,
  // arbitrary poll code
  parameter logic [15:0] POLL_CMD    = 16'h0700
) (
  input  wire logic        clk,
  input  wire logic        chipSelect_n,
  input  wire logic        sck,
  input  wire logic        sdi,
  input  wire logic        badPec,
  output logic             sdo,
  output logic             busy,
  output logic [15:0]      pecSeen,
  output logic [3:0]       goodGroups
);
  // ==========================================================
  // stack state seen from the bottom device
  logic [47:0] regs [N_DEV];
  logic [47:0] pend [N_DEV];
  logic        pendOk [N_DEV];
  logic [31:0] cmdSr;
  logic [63:0] sh;
  logic [15:0] pw;
  logic        cmdOk, startReq;
  int          rises, busyCnt, j, d;
  wire logic [15:0] cmd = cmdSr[31:16];

  function automatic logic [14:0] pec(input logic [47:0] v, input int n);
    logic [14:0] c;
    logic        fb;
    c = 15'h0010;
    for (int i = n - 1; i >= 0; i--) begin
      fb = v[i] ^ c[14];
      c  = {c[13:0], fb} ^ ({15{fb}} & 15'h4598);
    end
    return c;
  endfunction

  initial begin
    sdo = 1'b1;
    busy = 1'b0;
    startReq = 1'b0;
    busyCnt = 0;
    rises = 0;
    cmdOk = 1'b0;
    pecSeen = '0;
    goodGroups = '0;
    for (int i = 0; i < N_DEV; i++) begin
      regs[i] = '0;
      pendOk[i] = 1'b0;
    end
  end

  // ==========================================================
  // conversions, all devices together
  always @(posedge clk) begin
    if (startReq) begin
      busyCnt = BUSY_CYCLES;
      startReq = 1'b0;
    end else if (busyCnt > 0) begin
      busyCnt--;
    end
    busy = (busyCnt > 0);
  end

  always @(negedge chipSelect_n) begin
    rises = 0;
    cmdOk = 1'b0;
  end

  // writes land only on select release, and only for groups that checked out
  always @(posedge chipSelect_n) begin
    for (int i = 0; i < N_DEV; i++) begin
      if (pendOk[i]) regs[i] = pend[i];
      pendOk[i] = 1'b0;
    end
    sdo = 1'b1;
  end

  // ==========================================================
  // link: sample on rise and present the next output bit at once
  always @(posedge sck) begin
    if (!chipSelect_n) begin
      j = rises - 32;
      if (rises < 32) cmdSr = {cmdSr[30:0], sdi};
      else sh = {sh[62:0], sdi};
      if (rises >= 32 && cmdOk && cmd == WR_CMD && j % 64 == 63 && j < N_DEV * 64) begin
        d = N_DEV - 1 - j / 64;
        pend[d] = sh[63:16];
        pendOk[d] = (sh[15:0] == {pec(sh[63:16], 48), 1'b0});
        goodGroups = goodGroups + 4'(pendOk[d]);
      end
      sdo = 1'b1;
      if (rises >= 32 && cmdOk && (cmd == CONV_CMD || cmd == POLL_CMD))
        sdo = (j < N_DEV) ? 1'b0 : !busy;
      if (rises >= 32 && cmdOk && cmd == RD_CMD && j < N_DEV * 64) begin
        d = j / 64;
        pw = {pec(regs[d], 48), 1'b0} ^ (badPec ? 16'h0100 : 16'h0000);
        sdo = (j % 64 < 48) ? regs[d][47 - j % 64] : pw[63 - j % 64];
      end
      rises++;
      if (rises == 32) begin
        pecSeen = cmdSr[15:0];
        cmdOk = (cmdSr[15:0] == {pec({32'h0, cmdSr[31:16]}, 16), 1'b0});
        if (cmdOk && cmdSr[31:16] == CONV_CMD) startReq = 1'b1;
      end
    end
  end
endmodule // dev_chain
`default_nettype wire

// ### sim/tb_pec_link_host.sv
`timescale 1ns/100ps
`default_nettype none
module tb_pec_link_host;
  // ==========================================================
  // signals
  localparam logic [15:0] POLL = 16'h0700;
  typedef struct packed {
    logic [15:0] cmd;
    logic [15:0] pecWord;
  } row_type;
  logic clk, rst_n, reqValid, reqReady, wrValid, wrReady, rdValid, groupDone;
  logic checkOk, pollAbort, convDone, done, chipSelect_n, sck, sdi, sdo;
  logic badPec, busy, expOk;
  logic [7:0]                  wrByte;
  logic [15:0]                 pecSeen;
  logic [3:0]                  goodGroups;
  pec_link_pkg::request_type   req;
  pec_link_pkg::read_byte_type rdData;
  row_type                     rows [3];
  logic [7:0]                  wbytes [$];
  int err_count, checks_done, cyc, cnt, wi, groups, nBytes, convCount, convAt;

  pec_link_host u_pec_link_host (.clk, .rst_n, .reqValid, .reqReady, .req, .wrValid,
    .wrReady, .wrByte, .rdValid, .rdData, .groupDone, .checkOk, .pollAbort, .convDone,
    .done, .chipSelect_n, .sck, .sdi, .sdo);
  dev_chain #(.POLL_CMD(POLL)) u_dev_chain (.clk, .chipSelect_n, .sck, .sdi, .badPec,
    .sdo, .busy, .pecSeen, .goodGroups);

  always #5 clk = ~clk;

  function automatic logic [7:0] dv(input logic [3:0] dev, input logic [2:0] idx);
    return {dev, 1'b0, idx} ^ 8'hA5;
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      err_count++;
    end
  endtask

  task automatic report_and_stop;
    $display("counts: checks=%0d mismatches=%0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // ==========================================================
  // one whole frame; watches the user side every cycle until done
  task automatic frame(input pec_link_pkg::op_type op, input logic [15:0] c,
                       input logic [3:0] n, input int abortAt);
    logic took;
    req = '{op, c, n};
    reqValid = 1'b1;
    wrValid = (op == pec_link_pkg::OP_WRITE);
    wi = 0;
    cnt = 0;
    groups = 0;
    nBytes = 0;
    convCount = 0;
    wrByte = (wbytes.size() > 0) ? wbytes[0] : 8'h00;
    @(posedge clk);
    #1 reqValid = 1'b0;
    while (done !== 1'b1 && cnt < 40000) begin
      @(posedge clk);
      took = wrValid && wrReady;
      #1;
      cnt++;
      if (took) begin
        wi++;
        wrByte = (wi < wbytes.size()) ? wbytes[wi] : 8'h00;
      end
      if (cnt == abortAt) pollAbort = 1'b1;
      if (rdValid === 1'b1) begin
        check(rdData.data, dv(rdData.dev, rdData.index));
        check({rdData.dev, rdData.index}, {4'(nBytes / 6), 3'(nBytes % 6)});
        nBytes++;
      end
      if (groupDone === 1'b1) begin
        check(checkOk, expOk);
        groups++;
      end
      if (convDone === 1'b1) begin
        check(busy, 1'b0);
        convCount++;
        convAt = cnt;
      end
    end
    if (cnt >= 40000) err_count++;
    pollAbort = 1'b0;
    wrValid = 1'b0;
  endtask

  always @(posedge clk) begin
    cyc++;
    if (cyc == 90000) begin
      err_count++;
      report_and_stop();
    end
  end

  // ==========================================================
  // main sequence
  initial begin
    clk = 1'b0;
    rst_n = 1'b0;
    reqValid = 1'b0;
    req = '0;
    wrValid = 1'b0;
    wrByte = '0;
    pollAbort = 1'b0;
    badPec = 1'b0;
    expOk = 1'b1;
    err_count = 0;
    checks_done = 0;
    cyc = 0;
    rows[0] = '{16'h0001, 16'h3D6E};
    rows[1] = '{16'h0002, {u_dev_chain.pec(48'h0002, 16), 1'b0}};
    rows[2] = '{16'h0260, {u_dev_chain.pec(48'h0260, 16), 1'b0}};
    repeat (16) @(posedge clk);
    #1 rst_n = 1'b1;
    check({chipSelect_n, sck, sdi, reqReady, done}, 5'b10110);
    $display("test reset done");
    // the last row also starts a conversion for the poll tests
    for (int i = 0; i < 3; i++) begin
      frame(pec_link_pkg::OP_CMD, rows[i].cmd, 4'h1, 0);
      check(pecSeen, rows[i].pecWord);
    end
    $display("test command rows done");
    frame(pec_link_pkg::OP_POLL, POLL, 4'h2, 5000);
    check(convCount, 0);
    check(busy, 1'b1);
    $display("test poll abort done");
    frame(pec_link_pkg::OP_POLL, POLL, 4'h2, 0);
    check(convCount, 1);
    frame(pec_link_pkg::OP_POLL, POLL, 4'h2, 0);
    check(convAt >= 3450 && convAt <= 3600, 1);
    $display("test poll done");
    for (int g = 0; g < 2; g++) begin
      for (int b = 0; b < 6; b++) begin
        wbytes.push_back(dv(4'(1 - g), 3'(b)));
      end
    end
    frame(pec_link_pkg::OP_WRITE, 16'h0001, 4'h2, 0);
    check(goodGroups, 2);
    check(wi, 12);
    $display("test write done");
    frame(pec_link_pkg::OP_READ, 16'h0002, 4'h2, 0);
    check(nBytes, 12);
    check(groups, 2);
    $display("test read done");
    badPec = 1'b1;
    expOk = 1'b0;
    frame(pec_link_pkg::OP_READ, 16'h0002, 4'h1, 0);
    check(groups, 1);
    $display("test bad check word done");
    report_and_stop();
  end
endmodule // tb_pec_link_host
`default_nettype wire
